// ===== src/sls_cfg.svh
// Register offsets, field positions, reset values and timing counts
// for the sensorless start sequencer. Included by the design files.
`ifndef SLS_CFG_SVH
`define SLS_CFG_SVH

`define OFF_CTRL      8'h00
`define OFF_STATUS    8'h04
`define OFF_IRQ_STAT  8'h08
`define OFF_IRQ_MASK  8'h0C
`define OFF_COV_CUR   8'h10
`define OFF_COV_SPD   8'h14
`define OFF_COV_PHS   8'h18
`define OFF_CUR_NOISE 8'h1C
`define OFF_START_CUR 8'h20
`define OFF_CUR_RAMP  8'h24
`define OFF_INIT_SPD  8'h28
`define OFF_SPD_HYST  8'h2C
`define OFF_SPD_RAMP  8'h30
`define OFF_INIT_DLY  8'h34
`define OFF_STAND_CUR 8'h38
`define OFF_FAULT_SPD 8'h3C

`define CTRL_SWITCH_ON 0
`define CTRL_RUN       1
`define CTRL_ZC_STOP   2
`define CTRL_FB_LO     4
`define CTRL_FB_HI     6

`define FB_SENSORLESS  3'h4

// Covariance current, speed and noise scaled by 100; phase by 10000
`define COV_MIN        32'h0000_0001
`define COV_MAX        32'h0000_FDE8
`define COV_CUR_RST    32'h0000_0258
`define COV_SPD_RST    32'h0000_0064
`define COV_PHS_RST    32'h0000_0113
`define CUR_NOISE_RST  32'h0000_0064

`define IRQ_OVERSPEED  0
`define IRQ_HANDOVER   1
`define IRQ_FALLBACK   2
`define IRQ_REJECT     3

`define CLK_HZ         25000000
`define MS_PER_S       1000
`endif

// ===== src/sls_pkg.sv
// Types shared by the sensorless start sequencer files.
package sls_pkg;
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_STANDBY  = 3'b001,
    ST_ALIGN    = 3'b010,
    ST_DELAY    = 3'b011,
    ST_VF_RAMP  = 3'b100,
    ST_SENSLESS = 3'b101
  } seq_state_type;
endpackage : sls_pkg

// ===== src/sls_tick.sv
// Millisecond tick generator.
// Assumes a free-running aclk at the rate given by CLK_HZ.
`timescale 1ns/1ps
`include "sls_cfg.svh"
module sls_tick #(
  parameter int DIV = `CLK_HZ / `MS_PER_S
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  output logic      tick_q
);
  logic [24:0] cnt_q;
  wire         wrap = (cnt_q == 25'(DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= 25'h0;
      tick_q <= 1'b0;
    end else if (ce) begin
      cnt_q  <= wrap ? 25'h0 : cnt_q + 25'h1;
      tick_q <= wrap;
    end
  end
endmodule : sls_tick

// ===== src/sls_ramp.sv
// Linear ramp toward a target; steps once per tick by a fixed amount.
// Assumes tick is a one-cycle pulse in the aclk domain.
`timescale 1ns/1ps
module sls_ramp #(
  parameter int W = 16
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         clear,
  input  wire logic         tick,
  input  wire logic [W-1:0] target,
  input  wire logic [W-1:0] step,
  output logic      [W-1:0] value_q
);
  wire [W:0]   sum  = {1'b0, value_q} + {1'b0, step};
  wire         hit  = (sum >= {1'b0, target});
  wire [W-1:0] nxt  = hit ? target : sum[W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_q <= '0;
    end else if (ce) begin
      if (clear) value_q <= '0;
      else if (tick) value_q <= nxt;
    end
  end
endmodule : sls_ramp

// ===== src/sls_seq.sv
// Sensorless start sequencer with AXI4-Lite register slave.
// Assumes speed_meas and speed_ref are synchronous signed rpm values.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "sls_cfg.svh"

// Overview of operation
// - Sensorless operation only when feedback select field holds code 4.
// - Current covariance writes accepted only within 0.01 to 650.00.
// - Speed covariance writes accepted only within 0.01 to 650.00.
// - Phase covariance writes accepted only within 0.0001 to 6.5000.
// - Current noise writes accepted only within 0.01 to 650.00.
// - Sequence starts with alignment current, percent of nominal.
// - Alignment current ramps to starting current over set seconds.
// - V/F at or below initial speed, sensorless above it.
// - Speed hysteresis in rpm applies around the hand-over speed.
// - Speed ramps from zero to initial speed at set rpm per second; steps are whole rpm per ms, rounded down, at least 1 rpm.
// - Initial delay elapses before speed reference is followed.
// - Continuous zero crossing passes zero with no stop procedure.
// - Stop-start zero crossing returns to alignment, repeats start sequence.
// - On switch-on, standstill current at zero speed is driven.
// - Alarm whenever measured speed exceeds fault speed threshold.
// - Current covariance resets to 6.00.
module sls_seq
  import sls_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic signed [15:0] speed_ref,
  input  wire logic signed [15:0] speed_meas,
  output logic [7:0]              cur_cmd_q,
  output logic signed [15:0]      spd_cmd_q,
  output logic                    vf_mode_q,
  output logic                    sensorless_q,
  output logic                    alarm_q,
  output logic                    irq_q
);
  localparam int TICK_MS = 1;

  seq_state_type state_q;
  logic [31:0] ctrl_q, istat_q, imask_q;
  logic [31:0] cov_cur_q, cov_spd_q, cov_phs_q, cur_noise_q;
  logic [7:0]  start_cur_q, stand_cur_q;
  logic [15:0] cur_ramp_q, init_spd_q, spd_hyst_q, spd_ramp_q;
  logic [15:0] init_dly_q, fault_spd_q, dly_cnt_q;
  logic        ref_neg_q;
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;

  // Write channels taken in either order, response after both
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire do_wr   = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire [7:0]  waddr = aw_addr_q;
  wire [31:0] wdata = w_data_q;

  function automatic logic in_range(input logic [31:0] v);
    in_range = (v >= `COV_MIN) && (v <= `COV_MAX);
  endfunction : in_range

  function automatic logic is_cov(input logic [7:0] a);
    is_cov = (a == `OFF_COV_CUR) || (a == `OFF_COV_SPD) ||
             (a == `OFF_COV_PHS) || (a == `OFF_CUR_NOISE);
  endfunction : is_cov

  wire cov_ok   = in_range(wdata);
  wire reject   = do_wr && is_cov(waddr) && !cov_ok;
  wire wr_cov   = do_wr && cov_ok;
  wire [2:0] fb_sel = ctrl_q[`CTRL_FB_HI:`CTRL_FB_LO];
  wire sless_en = (fb_sel == `FB_SENSORLESS);
  wire sw_on    = ctrl_q[`CTRL_SWITCH_ON];
  wire run_en   = ctrl_q[`CTRL_RUN];
  wire zc_stop  = ctrl_q[`CTRL_ZC_STOP];

  // Ramp steps: speed per millisecond tick, current per cur_tick
  logic        tick;
  logic [7:0]  align_cur;
  logic [15:0] vf_spd;
  wire  [7:0]  cur_step = (cur_ramp_q == 16'h0) ? start_cur_q : 8'h1;
  wire  [15:0] spd_step = (spd_ramp_q < 16'(`MS_PER_S)) ? 16'h1 :
                          16'(spd_ramp_q / 16'(`MS_PER_S));
  logic [15:0] cur_div_q;
  wire  [15:0] cur_per = 16'(({16'h0, cur_ramp_q} * 32'(`MS_PER_S)) /
                         ({24'h0, start_cur_q} + 32'h1));
  wire cur_tick = tick && (cur_div_q >= cur_per);

  wire in_align = (state_q == ST_ALIGN);
  wire in_vf    = (state_q == ST_VF_RAMP);

  sls_tick u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .tick_q  (tick)
  );

  sls_ramp #(.W(8)) u_cur_ramp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .clear   (!in_align && state_q != ST_DELAY),
    .tick    (cur_tick),
    .target  (start_cur_q),
    .step    (cur_step),
    .value_q (align_cur)
  );

  sls_ramp #(.W(16)) u_spd_ramp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .clear   (!in_vf),
    .tick    (tick),
    .target  (init_spd_q),
    .step    (spd_step),
    .value_q (vf_spd)
  );

  wire [15:0] meas_abs = speed_meas[15] ? 16'(-speed_meas) : speed_meas;
  wire        ref_neg  = speed_ref[15];
  wire        reversal = (ref_neg != ref_neg_q) && (speed_ref != 16'sh0);
  wire [15:0] lo_thr   = (init_spd_q > spd_hyst_q) ?
                         16'(init_spd_q - spd_hyst_q) : 16'h0;
  wire over_init = meas_abs > init_spd_q;
  wire below_lo  = meas_abs < lo_thr;
  wire overspeed = meas_abs > fault_spd_q;
  wire dly_done  = (dly_cnt_q >= init_dly_q);
  wire handover  = in_vf && over_init;
  wire fallback  = (state_q == ST_SENSLESS) &&
                   (below_lo || (zc_stop && reversal));

  seq_state_type state_d;
  always_comb begin
    state_d = state_q;
    if (!sw_on || !sless_en) state_d = ST_IDLE;
    else unique case (state_q)
      ST_IDLE:     state_d = ST_STANDBY;
      ST_STANDBY:  if (run_en) state_d = ST_ALIGN;
      ST_ALIGN:    if (align_cur == start_cur_q) state_d = ST_DELAY;
      ST_DELAY:    if (dly_done) state_d = ST_VF_RAMP;
      ST_VF_RAMP:  if (!run_en) state_d = ST_STANDBY;
                   else if (over_init) state_d = ST_SENSLESS;
      ST_SENSLESS: if (!run_en) state_d = ST_STANDBY;
                   else if (zc_stop && reversal) state_d = ST_ALIGN;
                   else if (below_lo) state_d = ST_VF_RAMP;
      default:     state_d = ST_IDLE;
    endcase
  end

  // Continuous mode passes zero with no stop, falling back to V/F below the band
  wire [15:0] mag_cmd = in_vf ? vf_spd :
                        (state_q == ST_SENSLESS) ?
                        (speed_ref[15] ? 16'(-speed_ref) : speed_ref) :
                        16'h0;
  wire signed [15:0] spd_d = ref_neg ? 16'(-mag_cmd) : mag_cmd;
  wire [7:0] cur_d = (state_q == ST_STANDBY) ? stand_cur_q :
                     (in_align || state_q == ST_DELAY) ? align_cur :
                     8'h0;
  wire [3:0] ev = {reject, fallback, handover, overspeed};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= ST_IDLE;
      dly_cnt_q    <= 16'h0;
      cur_div_q    <= 16'h0;
      ref_neg_q    <= 1'b0;
      cur_cmd_q    <= 8'h0;
      spd_cmd_q    <= 16'sh0;
      vf_mode_q    <= 1'b0;
      sensorless_q <= 1'b0;
      alarm_q      <= 1'b0;
      irq_q        <= 1'b0;
    end else if (ce) begin
      state_q      <= state_d;
      // Zero keeps the old sign, so a reversal through zero is still seen
      if (speed_ref != 16'sh0) ref_neg_q <= ref_neg;
      if (state_q != ST_DELAY) dly_cnt_q <= 16'h0;
      else if (tick && !dly_done) dly_cnt_q <= dly_cnt_q + 16'(TICK_MS);
      if (!in_align || cur_tick) cur_div_q <= 16'h0;
      else if (tick) cur_div_q <= cur_div_q + 16'h1;
      cur_cmd_q    <= cur_d;
      spd_cmd_q    <= spd_d;
      vf_mode_q    <= in_vf;
      sensorless_q <= (state_q == ST_SENSLESS);
      alarm_q      <= overspeed;
      irq_q        <= |(istat_q & imask_q);
    end
  end

  // Register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= 32'h0000_0040;
      istat_q     <= 32'h0;
      imask_q     <= 32'h0;
      cov_cur_q   <= `COV_CUR_RST;
      cov_spd_q   <= `COV_SPD_RST;
      cov_phs_q   <= `COV_PHS_RST;
      cur_noise_q <= `CUR_NOISE_RST;
      start_cur_q <= 8'h32;
      stand_cur_q <= 8'h0A;
      cur_ramp_q  <= 16'h0001;
      init_spd_q  <= 16'h012C;
      spd_hyst_q  <= 16'h0032;
      spd_ramp_q  <= 16'h01F4;
      init_dly_q  <= 16'h01F4;
      fault_spd_q <= 16'h0FA0;
    end else if (ce) begin
      // Set wins over write-one-to-clear
      istat_q <= (istat_q & ~((do_wr && waddr == `OFF_IRQ_STAT) ?
                 wdata : 32'h0)) | {28'h0, ev};
      if (do_wr) begin
        unique case (waddr)
          `OFF_CTRL:      ctrl_q      <= {25'h0, wdata[6:0]};
          `OFF_IRQ_MASK:  imask_q     <= {28'h0, wdata[3:0]};
          `OFF_COV_CUR:   if (wr_cov) cov_cur_q   <= wdata;
          `OFF_COV_SPD:   if (wr_cov) cov_spd_q   <= wdata;
          `OFF_COV_PHS:   if (wr_cov) cov_phs_q   <= wdata;
          `OFF_CUR_NOISE: if (wr_cov) cur_noise_q <= wdata;
          `OFF_START_CUR: start_cur_q <= wdata[7:0];
          `OFF_CUR_RAMP:  cur_ramp_q  <= wdata[15:0];
          `OFF_INIT_SPD:  init_spd_q  <= wdata[15:0];
          `OFF_SPD_HYST:  spd_hyst_q  <= wdata[15:0];
          `OFF_SPD_RAMP:  spd_ramp_q  <= wdata[15:0];
          `OFF_INIT_DLY:  init_dly_q  <= wdata[15:0];
          `OFF_STAND_CUR: stand_cur_q <= wdata[7:0];
          `OFF_FAULT_SPD: fault_spd_q <= wdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // AXI write handshake; writes ignore wstrb and update the whole word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h0;
      w_data_q      <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else if (ce) begin
      s_axi_awready <= !aw_hold_q && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= !w_hold_q && !w_take && !s_axi_bvalid;
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (waddr > `OFF_FAULT_SPD || reject) ? 2'b10 : 2'b00;
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire [7:0] raddr = {s_axi_araddr[7:2], 2'b00};
  wire [31:0] rmux =
    (raddr == `OFF_CTRL)      ? ctrl_q :
    (raddr == `OFF_STATUS)    ? {27'h0, alarm_q, 1'b0, state_q} :
    (raddr == `OFF_IRQ_STAT)  ? istat_q :
    (raddr == `OFF_IRQ_MASK)  ? imask_q :
    (raddr == `OFF_COV_CUR)   ? cov_cur_q :
    (raddr == `OFF_COV_SPD)   ? cov_spd_q :
    (raddr == `OFF_COV_PHS)   ? cov_phs_q :
    (raddr == `OFF_CUR_NOISE) ? cur_noise_q :
    (raddr == `OFF_START_CUR) ? {24'h0, start_cur_q} :
    (raddr == `OFF_CUR_RAMP)  ? {16'h0, cur_ramp_q} :
    (raddr == `OFF_INIT_SPD)  ? {16'h0, init_spd_q} :
    (raddr == `OFF_SPD_HYST)  ? {16'h0, spd_hyst_q} :
    (raddr == `OFF_SPD_RAMP)  ? {16'h0, spd_ramp_q} :
    (raddr == `OFF_INIT_DLY)  ? {16'h0, init_dly_q} :
    (raddr == `OFF_STAND_CUR) ? {24'h0, stand_cur_q} :
    (raddr == `OFF_FAULT_SPD) ? {16'h0, fault_spd_q} : 32'h0;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rmux;
        s_axi_rresp  <= (raddr > `OFF_FAULT_SPD) ? 2'b10 : 2'b00;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  fb_gate_a: assert property (sensorless_q |-> $past(sless_en, 2))
    else $error("sensorless without feedback code 4");
  cov_keep_a: assert property (reject |=> $stable(cov_cur_q) &&
      $stable(cov_spd_q) && $stable(cov_phs_q) && $stable(cur_noise_q))
    else $error("rejected write changed a covariance");
  cov_range_a: assert property (in_range(cov_cur_q) &&
      in_range(cov_spd_q) && in_range(cov_phs_q) && in_range(cur_noise_q))
    else $error("covariance out of range");
  align_cur_a: assert property (in_align |=>
      cur_cmd_q == $past(align_cur))
    else $error("alignment current not driven");
  hand_over_a: assert property (handover && run_en &&
      sw_on && sless_en |=> state_q == ST_SENSLESS ##1 sensorless_q)
    else $error("no hand-over above initial speed");
  fall_back_a: assert property ($fell(sensorless_q) && vf_mode_q
      |-> $past(below_lo, 2))
    else $error("fallback above hysteresis band");
  delay_hold_a: assert property (state_q == ST_DELAY && !dly_done
      |=> state_q != ST_VF_RAMP)
    else $error("speed ramp before initial delay");
  zc_stop_a: assert property (state_q == ST_SENSLESS && zc_stop &&
      reversal && run_en && sw_on && sless_en |=> state_q == ST_ALIGN)
    else $error("stop-start did not restart");
  stand_cur_a: assert property (state_q == ST_STANDBY |=>
      cur_cmd_q == $past(stand_cur_q) && spd_cmd_q == 16'sh0)
    else $error("standstill current wrong");
  over_spd_a: assert property (overspeed |=> alarm_q && istat_q[0])
    else $error("overspeed alarm missing");

  hand_c: cover property (handover ##[1:4] sensorless_q);
  fall_c: cover property (fallback ##1 vf_mode_q);
  rej_c:  cover property (reject ##1 s_axi_bvalid);
  irq_c:  cover property ($rose(irq_q));
endmodule : sls_seq

// ===== test/pm_motor.sv
// Behavioural permanent-magnet motor seen through the power stage.
// Assumes the bench may pin the measured speed to a chosen value.
`timescale 1ns/1ps
module pm_motor (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic signed [15:0] spd_cmd,
  input  wire logic               pin_en,
  input  wire logic signed [15:0] pin_spd,
  output logic signed [15:0]      speed_meas
);
  // Rotor inertia: one rpm per cycle toward the command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_meas <= 16'sh0000;
    end else if (pin_en) begin
      speed_meas <= pin_spd;
    end else if (speed_meas < spd_cmd) begin
      speed_meas <= speed_meas + 16'sh0001;
    end else if (speed_meas > spd_cmd) begin
      speed_meas <= speed_meas - 16'sh0001;
    end
  end
endmodule : pm_motor

// ===== test/sensorless_startup_sequencer_bench.sv
// Self-checking bench for the sensorless start sequencer.
// Assumes the design answers AXI4-Lite and a motor model closes the loop.
`timescale 1ns/1ps
`include "sls_cfg.svh"
module sensorless_startup_sequencer_bench;
  import sls_pkg::*;
  logic               aclk          = 1'b0;
  logic               aresetn       = 1'b0;
  logic [7:0]         s_axi_awaddr  = 8'h00;
  logic               s_axi_awvalid = 1'b0;
  logic [31:0]        s_axi_wdata   = 32'h0000_0000;
  logic               s_axi_wvalid  = 1'b0;
  logic               s_axi_bready  = 1'b0;
  logic [7:0]         s_axi_araddr  = 8'h00;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_rready  = 1'b0;
  logic signed [15:0] speed_ref     = 16'sh01F4;
  logic               pin_en        = 1'b0;
  logic signed [15:0] pin_spd       = 16'sh0000;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic               s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic [31:0]        s_axi_rdata, d;
  logic signed [15:0] speed_meas, spd_cmd_q;
  logic [7:0]         cur_cmd_q;
  logic               vf_mode_q, sensorless_q, alarm_q, irq_q;
  logic [31:0]        rst_val [4];
  int                 n_errors, comparisons, i;

  always #20 aclk = ~aclk;

  sls_seq DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .speed_ref(speed_ref),
    .speed_meas(speed_meas), .cur_cmd_q(cur_cmd_q),
    .spd_cmd_q(spd_cmd_q), .vf_mode_q(vf_mode_q),
    .sensorless_q(sensorless_q), .alarm_q(alarm_q), .irq_q(irq_q));

  pm_motor motor (.aclk(aclk), .aresetn(aresetn), .spd_cmd(spd_cmd_q),
    .pin_en(pin_en), .pin_spd(pin_spd), .speed_meas(speed_meas));

  task check(input string name, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // Entry edge first, so a release never meets a new request
  task wchk(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask : wchk

  task rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask : rd

  task rchk(input logic [7:0] a, input logic [31:0] ed);
    rd(a, 2'h0);
    check("rdata", ed, d);
  endtask : rchk

  // Pin the motor speed, then let the one-cycle-late outputs settle
  task pin(input logic signed [15:0] v);
    @(posedge aclk);
    pin_spd <= v;
    pin_en  <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask : pin

  initial begin
    repeat (90000) @(posedge aclk);
    n_errors++;
    $display("BAD watchdog expected done seen hang");
    end_of_test();
  end

  initial begin
    rst_val = '{`COV_CUR_RST, `COV_SPD_RST, `COV_PHS_RST, `CUR_NOISE_RST};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(`OFF_COV_CUR, `COV_CUR_RST);
    rchk(`OFF_CTRL, 32'h0000_0040);
    for (i = 0; i < 4; i++) begin
      wchk(`OFF_COV_CUR + 8'(4 * i), 32'h0000_0000, 2'h2);
      wchk(`OFF_COV_CUR + 8'(4 * i), 32'h0000_FDE9, 2'h2);
      rchk(`OFF_COV_CUR + 8'(4 * i), rst_val[i]);
      wchk(`OFF_COV_CUR + 8'(4 * i), `COV_MIN, 2'h0);
      rchk(`OFF_COV_CUR + 8'(4 * i), `COV_MIN);
      wchk(`OFF_COV_CUR + 8'(4 * i), `COV_MAX, 2'h0);
      rchk(`OFF_COV_CUR + 8'(4 * i), `COV_MAX);
    end
    rchk(`OFF_IRQ_STAT, 32'h0000_0008);
    check("irq_q", 32'h0, {31'h0, irq_q});
    wchk(`OFF_IRQ_MASK, 32'h0000_000F, 2'h0);
    repeat (2) @(posedge aclk);
    check("irq_q", 32'h1, {31'h0, irq_q});
    wchk(`OFF_IRQ_STAT, 32'h0000_0008, 2'h0);
    repeat (2) @(posedge aclk);
    check("irq_q", 32'h0, {31'h0, irq_q});
    rd(8'h40, 2'h2);
    check("unmapped", 32'h0, d);
    wchk(8'h40, 32'h0000_0001, 2'h2);
    wchk(`OFF_FAULT_SPD, 32'd1000, 2'h0);
    pin(16'sd1500);
    check("alarm_q", 32'h1, {31'h0, alarm_q});
    rd(`OFF_STATUS, 2'h0);
    check("status alarm", 32'h1, {31'h0, d[4]});
    pin(-16'sd1500);
    check("alarm_q", 32'h1, {31'h0, alarm_q});
    pin(16'sd1000);
    check("alarm_q", 32'h0, {31'h0, alarm_q});
    rd(`OFF_IRQ_STAT, 2'h0);
    check("overspeed irq", 32'h1, {31'h0, d[0]});
    wchk(`OFF_IRQ_STAT, 32'h0000_000F, 2'h0);
    pin(16'sd0);
    wchk(`OFF_STAND_CUR, 32'd20, 2'h0);
    wchk(`OFF_CTRL, 32'h0000_0041, 2'h0);
    repeat (3) @(posedge aclk);
    rd(`OFF_STATUS, 2'h0);
    check("state", {29'h0, ST_STANDBY}, {29'h0, d[2:0]});
    check("cur_cmd_q", 32'd20, {24'h0, cur_cmd_q});
    check("spd_cmd_q", 32'h0, {16'h0, spd_cmd_q});
    wchk(`OFF_INIT_SPD, 32'd200, 2'h0);
    wchk(`OFF_SPD_HYST, 32'd50, 2'h0);
    wchk(`OFF_CUR_RAMP, 32'd0, 2'h0);
    wchk(`OFF_INIT_DLY, 32'd0, 2'h0);
    wchk(`OFF_START_CUR, 32'd30, 2'h0);
    wchk(`OFF_SPD_RAMP, 32'd1000, 2'h0);
    wchk(`OFF_CTRL, 32'h0000_0003, 2'h0);
    pin(16'sd500);
    repeat (200) @(posedge aclk);
    check("sensorless_q", 32'h0, {31'h0, sensorless_q});
    wchk(`OFF_CTRL, 32'h0000_0041, 2'h0);
    pin(16'sd0);
    wchk(`OFF_CTRL, 32'h0000_0043, 2'h0);
    for (i = 0; i < 60000 && vf_mode_q !== 1'b1; i++) @(posedge aclk);
    check("vf_mode_q", 32'h1, {31'h0, vf_mode_q});
    check("spd_cmd_q cap", 32'h1, {31'h0, spd_cmd_q <= 16'sd200});
    // One millisecond step at 1000 rpm/s, motor pinned at standstill
    repeat (30000) @(posedge aclk);
    check("spd ramp", 32'h0000_0001, {16'h0, spd_cmd_q});
    pin(16'sd200);
    check("sensorless_q", 32'h0, {31'h0, sensorless_q});
    pin(16'sd201);
    check("sensorless_q", 32'h1, {31'h0, sensorless_q});
    check("vf_mode_q", 32'h0, {31'h0, vf_mode_q});
    pin(16'sd160);
    check("sensorless_q", 32'h1, {31'h0, sensorless_q});
    pin(16'sd149);
    check("vf_mode_q", 32'h1, {31'h0, vf_mode_q});
    rd(`OFF_IRQ_STAT, 2'h0);
    check("handover irqs", 32'h6, {29'h0, d[2:0]});
    pin(16'sd300);
    check("sensorless_q", 32'h1, {31'h0, sensorless_q});
    speed_ref <= -16'sd500;
    repeat (10) @(posedge aclk);
    check("sensorless_q", 32'h1, {31'h0, sensorless_q});
    check("spd_cmd_q", 32'h0000_FE0C, {16'h0, spd_cmd_q});
    wchk(`OFF_CTRL, 32'h0000_0047, 2'h0);
    speed_ref <= 16'sd500;
    repeat (3) @(posedge aclk);
    check("sensorless_q", 32'h0, {31'h0, sensorless_q});
    end_of_test();
  end
endmodule : sensorless_startup_sequencer_bench
